// ==== testbench/flash_dev_model.sv ====
// behavioural flash device answering status reads and commands
`timescale 1ns/1ps
module flash_dev_model (
  // flash pins
  input wire logic [19:0] i_addr,
  input wire logic i_ce_n,
  input wire logic i_oe_n,
  input wire logic i_we_n,
  input wire logic [7:0] i_data,
  input wire logic i_data_oe,
  output logic [7:0] o_data,
  output logic o_ready_busy_n
);
  // algorithm state, preset by the bench
  logic run = 1'b0, erase = 1'b0, fail = 1'b0, pbit = 1'b0;
  logic btgl = 1'b0, stgl = 1'b0, in_rd = 1'b0, saw_reset = 1'b0;
  logic [7:0] arr = 8'h00, last = 8'h00, sel = 8'h00;
  logic [7:0] cur;
  logic rd_act, wr_act, win;
  int flips = 0, win_cnt = 0, win_len = 1000, n_reads = 0;

  assign rd_act = !i_ce_n && !i_oe_n;
  assign wr_act = !i_ce_n && !i_we_n;
  // only the sector erase command opens a window
  assign win = erase && (win_cnt >= win_len);
  assign o_ready_busy_n = !run;
  // released bus shows inverse of the last byte
  assign o_data = rd_act ? cur : ~last;

  always_comb begin
    if (run) begin
      cur = {erase ? 1'b0 : !pbit, btgl, fail, 1'b0, win, stgl, 2'b00};
    end else begin
      cur = arr;
    end
  end

  always @(posedge rd_act) begin
    in_rd = 1'b1;
  end

  // toggles advance at the end of each framed read
  always @(negedge rd_act) begin
    if (in_rd) begin
      in_rd = 1'b0;
      last = cur;
      n_reads++;
      if (erase) begin
        win_cnt++;
      end
      if (run && flips > 0) begin
        flips--;
        btgl = !btgl;
        if (erase && i_addr[19:12] == sel) begin
          stgl = !stgl;
        end
        if (flips == 0 && !fail) begin
          run = 1'b0;
          erase = 1'b0;
        end
      end
    end
  end

  // commands latch at the end of the write pulse
  always @(negedge wr_act) begin
    if (i_data_oe === 1'b1) begin
      if (i_data == flash_status_pkg::FLASH_RESET_CMD) begin
        run = 1'b0;
        erase = 1'b0;
        fail = 1'b0;
        saw_reset = 1'b1;
      end else if (i_data == flash_status_pkg::FLASH_ERASE_CMD && !win) begin
        run = 1'b1;
        erase = 1'b1;
        win_cnt = 0;
        flips = 1000;
        sel = i_addr[19:12];
      end
    end
  end
endmodule : flash_dev_model

// ==== testbench/flash_status_host_tb_top.sv ====
// self-checking bench for the flash status host controller
`timescale 1ns/1ps
module flash_status_host_tb_top;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [3:0] i_addr = 4'h0;
  logic [31:0] i_wr_data = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [31:0] o_rd_data, v;
  logic [19:0] f_addr;
  logic ce_n, oe_n, we_n, d_oe, rb_n;
  logic [7:0] d_to, d_from, d_wire;
  int bad_count = 0;
  int n_checks = 0;

  // data wire level from both drivers
  assign d_wire = d_oe ? d_to : d_from;

  flash_status_host dut (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wr_data(i_wr_data),
    .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data), .o_flash_addr(f_addr),
    .o_ce_n(ce_n), .o_oe_n(oe_n), .o_we_n(we_n), .i_data(d_wire), .o_data(d_to),
    .o_data_oe(d_oe), .i_ready_busy_n_out(rb_n)
  );

  flash_dev_model mdl (
    .i_addr(f_addr), .i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n), .i_data(d_wire),
    .i_data_oe(d_oe), .o_data(d_from), .o_ready_busy_n(rb_n)
  );

  initial begin
    forever #5 i_clk = ~i_clk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wr_data <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    v = o_rd_data;
  endtask : rd

  // start a command, optionally poke the address mid-run, wait and compare status
  task automatic op(input logic [1:0] cmd, input logic ce, input logic bump,
                    input logic [31:0] mask, input logic [31:0] exp);
    mdl.n_reads = 0;
    wr(flash_status_pkg::REG_CTRL, {28'h0, ce, 1'b1, cmd});
    rd(flash_status_pkg::REG_STATUS);
    check(v & 32'h1, 32'h1);
    if (bump) begin
      wr(flash_status_pkg::REG_ADDR, 32'h77777);
    end
    for (int i = 0; i < 100 && v[0] !== 1'b0; i++) begin
      rd(flash_status_pkg::REG_STATUS);
    end
    // a hung operation must not pass a masked compare
    check(v & 32'h1, 32'h0);
    check(v & mask, exp);
  endtask : op

  // erase running with toggles still going
  task automatic busy_dev(input logic f, input int n);
    mdl.run = 1'b1;
    mdl.erase = 1'b1;
    mdl.fail = f;
    mdl.flips = n;
    mdl.btgl = 1'b0;
    mdl.win_cnt = 1000;
  endtask : busy_dev

  task automatic stop_test;
    if (bad_count == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test

  initial begin
    #200000;
    bad_count++;
    stop_test();
  end

  initial begin
    mdl.arr = 8'h5a;
    repeat (2) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    rd(flash_status_pkg::REG_CTRL);
    check(v, 32'h0);
    rd(flash_status_pkg::REG_ADDR);
    check(v, 32'h0);
    rd(4'h2);
    check(v, 32'h0);
    repeat (4) @(posedge i_clk);
    rd(flash_status_pkg::REG_STATUS);
    check(v & 32'h1ff, 32'h100);
    // control write without go changes nothing
    wr(flash_status_pkg::REG_CTRL, 32'h9);
    rd(flash_status_pkg::REG_CTRL);
    check(v, 32'h0);
    wr(flash_status_pkg::REG_ADDR, 32'hfff12345);
    rd(flash_status_pkg::REG_ADDR);
    check(v, 32'h12345);
    // idle device gives array data, two equal reads mean done
    op(flash_status_pkg::CMD_STATUS, 1'b0, 1'b0, 32'h1, 32'h0);
    rd(flash_status_pkg::REG_DATA);
    check(v, 32'h5a);
    op(flash_status_pkg::CMD_CHECK, 1'b0, 1'b0, 32'h10e, 32'h102);
    check(mdl.n_reads, 2);
    // erase in selected sector, output-enable framing
    busy_dev(1'b0, 1000);
    mdl.sel = 8'h12;
    op(flash_status_pkg::CMD_CHECK, 1'b0, 1'b0, 32'h13c, 32'h38);
    check(mdl.n_reads, 2);
    rd(flash_status_pkg::REG_DATA);
    check(v & 32'ha8, 32'h08);
    // outside the sector, chip-enable framing, address write refused while busy
    wr(flash_status_pkg::REG_ADDR, 32'h0);
    op(flash_status_pkg::CMD_CHECK, 1'b1, 1'b1, 32'h11c, 32'h8);
    check(mdl.n_reads, 2);
    rd(flash_status_pkg::REG_ADDR);
    check(v, 32'h0);
    rd(flash_status_pkg::REG_CTRL);
    check(v, 32'h8);
    // still toggling with fail high: recheck, then reset
    busy_dev(1'b1, 1000);
    mdl.saw_reset = 1'b0;
    op(flash_status_pkg::CMD_CHECK, 1'b0, 1'b0, 32'h10c, 32'h104);
    check(mdl.n_reads, 3);
    check(mdl.saw_reset, 1);
    // toggle stops just as fail rises: recheck says done
    busy_dev(1'b1, 1);
    op(flash_status_pkg::CMD_CHECK, 1'b0, 1'b0, 32'he, 32'h2);
    check(mdl.n_reads, 3);
    mdl.saw_reset = 1'b0;
    op(flash_status_pkg::CMD_RESET, 1'b0, 1'b0, 32'h1, 32'h0);
    check(mdl.saw_reset, 1);
    // program in progress shows inverse data-poll bit
    busy_dev(1'b0, 1000);
    mdl.erase = 1'b0;
    op(flash_status_pkg::CMD_STATUS, 1'b0, 1'b0, 32'h100, 32'h0);
    rd(flash_status_pkg::REG_DATA);
    check(v & 32'h80, 32'h80);
    // added sector erase: window open before and after
    busy_dev(1'b0, 1000);
    mdl.win_cnt = 0;
    wr(flash_status_pkg::REG_ADDR, 32'h34000);
    op(flash_status_pkg::CMD_ADD_ERASE, 1'b0, 1'b0, 32'he0, 32'h0);
    check(mdl.sel, 32'h34);
    // window closes between the two checks: add not taken
    mdl.win_cnt = 999;
    wr(flash_status_pkg::REG_ADDR, 32'h56000);
    op(flash_status_pkg::CMD_ADD_ERASE, 1'b0, 1'b0, 32'he0, 32'ha0);
    check(mdl.sel, 32'h34);
    // window already closed: add refused
    wr(flash_status_pkg::REG_ADDR, 32'h78000);
    op(flash_status_pkg::CMD_ADD_ERASE, 1'b0, 1'b0, 32'he0, 32'h60);
    check(mdl.sel, 32'h34);
    stop_test();
  end
endmodule : flash_status_host_tb_top

// ==== verilog/flash_status_host.sv ====
// host controller that polls flash write-operation status bits
//
// Implementation choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module flash_status_host #(
  parameter int ADDR_W = 20
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // register port
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wr_data,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rd_data,
  // flash pins
  output logic [ADDR_W-1:0] o_flash_addr,
  output logic o_ce_n,
  output logic o_oe_n,
  output logic o_we_n,
  input wire logic [7:0] i_data,
  output logic [7:0] o_data,
  output logic o_data_oe,
  input wire logic i_ready_busy_n_out
);

  flash_status_pkg::state_type state_q, state_d;
  logic [1:0] op_q, op_d;
  logic [1:0] step_q, step_d;
  logic [4:0] cnt_q, cnt_d;
  logic is_wr_q, is_wr_d;
  logic ce_frame_q, ce_frame_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic ce_n_q, ce_n_d;
  logic oe_n_q, oe_n_d;
  logic we_n_q, we_n_d;
  logic [7:0] dout_q, dout_d;
  logic doe_q, doe_d;
  logic [7:0] prev_q, prev_d;
  logic [7:0] last_q, last_d;
  logic flash_done_q, flash_done_d;
  logic failed_q, failed_d;
  logic toggling_q, toggling_d;
  logic sect_q, sect_d;
  logic window_q, window_d;
  logic refused_q, refused_d;
  logic not_acc_q, not_acc_d;
  logic [31:0] rd_data_q, rd_data_d;
  logic [1:0] rd_cnt_q, rd_cnt_d;

  logic [8:0] pin_sync;
  logic [7:0] data_sync;
  logic ready_sync;
  logic busy_tgl;
  logic sect_tgl;
  logic go;
  logic [1:0] cmd;

  sync2 #(
    .WIDTH(9)
  ) pin_sync_u (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_async({i_ready_busy_n_out, i_data}),
    .o_sync(pin_sync)
  );

  assign data_sync = pin_sync[7:0];
  assign ready_sync = pin_sync[8];
  // compare the last two captured bytes
  assign busy_tgl = last_q[flash_status_pkg::BIT_BUSY_TGL] ^ prev_q[flash_status_pkg::BIT_BUSY_TGL];
  assign sect_tgl = last_q[flash_status_pkg::BIT_SECT_TGL] ^ prev_q[flash_status_pkg::BIT_SECT_TGL];
  assign go = i_wr && (i_addr == flash_status_pkg::REG_CTRL) && i_wr_data[flash_status_pkg::CTRL_GO_BIT];
  assign cmd = i_wr_data[flash_status_pkg::CTRL_CMD_LSB +: 2];

  always_comb begin
    logic launch_rd;
    logic launch_wr;
    logic finish;
    logic [7:0] wr_byte;
    launch_rd = 1'b0;
    launch_wr = 1'b0;
    finish = 1'b0;
    wr_byte = flash_status_pkg::FLASH_RESET_CMD;
    state_d = state_q;
    op_d = op_q;
    step_d = step_q;
    cnt_d = cnt_q;
    is_wr_d = is_wr_q;
    ce_frame_d = ce_frame_q;
    addr_d = addr_q;
    ce_n_d = ce_n_q;
    oe_n_d = oe_n_q;
    we_n_d = we_n_q;
    dout_d = dout_q;
    doe_d = doe_q;
    prev_d = prev_q;
    last_d = last_q;
    flash_done_d = flash_done_q;
    failed_d = failed_q;
    toggling_d = toggling_q;
    sect_d = sect_q;
    window_d = window_q;
    refused_d = refused_q;
    not_acc_d = not_acc_q;
    rd_cnt_d = rd_cnt_q;
    rd_data_d = 32'h00000000;
    // register reads
    if (i_rd) begin
      case (i_addr)
        flash_status_pkg::REG_CTRL: rd_data_d = {28'h0000000, ce_frame_q, 1'b0, op_q};
        flash_status_pkg::REG_ADDR: rd_data_d = 32'(addr_q);
        flash_status_pkg::REG_STATUS: begin
          rd_data_d[flash_status_pkg::ST_BUSY] = (state_q != flash_status_pkg::ST_IDLE);
          rd_data_d[flash_status_pkg::ST_FLASH_DONE] = flash_done_q;
          rd_data_d[flash_status_pkg::ST_FAILED] = failed_q;
          rd_data_d[flash_status_pkg::ST_TOGGLING] = toggling_q;
          rd_data_d[flash_status_pkg::ST_SECT_TGL] = sect_q;
          rd_data_d[flash_status_pkg::ST_WINDOW] = window_q;
          rd_data_d[flash_status_pkg::ST_REFUSED] = refused_q;
          rd_data_d[flash_status_pkg::ST_NOT_ACC] = not_acc_q;
          rd_data_d[flash_status_pkg::ST_READY] = ready_sync;
        end
        flash_status_pkg::REG_DATA: rd_data_d = {24'h000000, last_q};
        default: rd_data_d = 32'h00000000;
      endcase
    end
    case (state_q)
      flash_status_pkg::ST_IDLE: begin
        // address the status location; ignored while an operation runs
        if (i_wr && (i_addr == flash_status_pkg::REG_ADDR)) begin
          addr_d = i_wr_data[ADDR_W-1:0];
        end
        if (go) begin
          // every check starts again from its first read
          op_d = cmd;
          step_d = 2'h0;
          rd_cnt_d = 2'h0;
          ce_frame_d = i_wr_data[flash_status_pkg::CTRL_CE_FRAME_BIT];
          flash_done_d = 1'b0;
          failed_d = 1'b0;
          toggling_d = 1'b0;
          sect_d = 1'b0;
          refused_d = 1'b0;
          not_acc_d = 1'b0;
          if (cmd == flash_status_pkg::CMD_RESET) begin
            launch_wr = 1'b1;
          end else begin
            launch_rd = 1'b1;
          end
        end
      end
      flash_status_pkg::ST_ACT: begin
        cnt_d = cnt_q + 5'h01;
        if (is_wr_q && (cnt_q == flash_status_pkg::T_WP_CYC - 5'h01)) begin
          we_n_d = 1'b1;
          ce_n_d = 1'b1;
          cnt_d = 5'h00;
          state_d = flash_status_pkg::ST_REC;
        end else if (!is_wr_q && (cnt_q == flash_status_pkg::T_CAPTURE)) begin
          // capture the whole byte, keep the one before for comparison
          prev_d = last_q;
          last_d = data_sync;
          rd_cnt_d = (rd_cnt_q == 2'h3) ? rd_cnt_q : rd_cnt_q + 2'h1;
          // end the framing strobe so the device advances its toggles
          if (ce_frame_q) begin
            ce_n_d = 1'b1;
          end else begin
            oe_n_d = 1'b1;
          end
          cnt_d = 5'h00;
          state_d = flash_status_pkg::ST_REC;
        end
      end
      flash_status_pkg::ST_REC: begin
        doe_d = 1'b0;
        cnt_d = cnt_q + 5'h01;
        if (cnt_q == flash_status_pkg::T_REC_CYC - 5'h01) begin
          state_d = flash_status_pkg::ST_EVAL;
        end
      end
      flash_status_pkg::ST_EVAL: begin
        case (op_q)
          flash_status_pkg::CMD_CHECK: begin
            if (step_q == 2'h0) begin
              step_d = 2'h1;
              launch_rd = 1'b1;
            end else if (step_q == 2'h1) begin
              sect_d = sect_tgl;
              if (!busy_tgl) begin
                flash_done_d = 1'b1;
                finish = 1'b1;
              end else if (last_q[flash_status_pkg::BIT_FAIL]) begin
                step_d = 2'h2;
                launch_rd = 1'b1;
              end else begin
                toggling_d = 1'b1;
                finish = 1'b1;
              end
            end else if (step_q == 2'h2) begin
              if (!busy_tgl) begin
                flash_done_d = 1'b1;
                finish = 1'b1;
              end else begin
                failed_d = 1'b1;
                step_d = 2'h3;
                launch_wr = 1'b1;
              end
            end else begin
              finish = 1'b1;
            end
          end
          flash_status_pkg::CMD_STATUS: begin
            window_d = last_q[flash_status_pkg::BIT_WINDOW];
            finish = 1'b1;
          end
          flash_status_pkg::CMD_ADD_ERASE: begin
            if (step_q == 2'h0) begin
              // window check before adding a sector
              window_d = last_q[flash_status_pkg::BIT_WINDOW];
              if (last_q[flash_status_pkg::BIT_WINDOW]) begin
                refused_d = 1'b1;
                finish = 1'b1;
              end else begin
                step_d = 2'h1;
                wr_byte = flash_status_pkg::FLASH_ERASE_CMD;
                launch_wr = 1'b1;
              end
            end else if (step_q == 2'h1) begin
              step_d = 2'h2;
              launch_rd = 1'b1;
            end else begin
              window_d = last_q[flash_status_pkg::BIT_WINDOW];
              not_acc_d = last_q[flash_status_pkg::BIT_WINDOW];
              finish = 1'b1;
            end
          end
          default: finish = 1'b1;
        endcase
      end
      default: finish = 1'b1;
    endcase
    if (launch_rd) begin
      state_d = flash_status_pkg::ST_ACT;
      cnt_d = 5'h00;
      is_wr_d = 1'b0;
      ce_n_d = 1'b0;
      oe_n_d = 1'b0;
      we_n_d = 1'b1;
      doe_d = 1'b0;
    end else if (launch_wr) begin
      state_d = flash_status_pkg::ST_ACT;
      cnt_d = 5'h00;
      is_wr_d = 1'b1;
      ce_n_d = 1'b0;
      oe_n_d = 1'b1;
      we_n_d = 1'b0;
      dout_d = wr_byte;
      doe_d = 1'b1;
    end else if (finish) begin
      state_d = flash_status_pkg::ST_IDLE;
      ce_n_d = 1'b1;
      oe_n_d = 1'b1;
      we_n_d = 1'b1;
      doe_d = 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_q <= flash_status_pkg::ST_IDLE;
      op_q <= flash_status_pkg::CMD_CHECK;
      step_q <= 2'h0;
      cnt_q <= 5'h00;
      is_wr_q <= 1'b0;
      ce_frame_q <= 1'b0;
      addr_q <= '0;
      ce_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      we_n_q <= 1'b1;
      dout_q <= 8'h00;
      doe_q <= 1'b0;
      prev_q <= 8'h00;
      last_q <= 8'h00;
      flash_done_q <= 1'b0;
      failed_q <= 1'b0;
      toggling_q <= 1'b0;
      sect_q <= 1'b0;
      window_q <= 1'b0;
      refused_q <= 1'b0;
      not_acc_q <= 1'b0;
      rd_data_q <= 32'h00000000;
      rd_cnt_q <= 2'h0;
    end else begin
      state_q <= state_d;
      op_q <= op_d;
      step_q <= step_d;
      cnt_q <= cnt_d;
      is_wr_q <= is_wr_d;
      ce_frame_q <= ce_frame_d;
      addr_q <= addr_d;
      ce_n_q <= ce_n_d;
      oe_n_q <= oe_n_d;
      we_n_q <= we_n_d;
      dout_q <= dout_d;
      doe_q <= doe_d;
      prev_q <= prev_d;
      last_q <= last_d;
      flash_done_q <= flash_done_d;
      failed_q <= failed_d;
      toggling_q <= toggling_d;
      sect_q <= sect_d;
      window_q <= window_d;
      refused_q <= refused_d;
      not_acc_q <= not_acc_d;
      rd_data_q <= rd_data_d;
      rd_cnt_q <= rd_cnt_d;
    end
  end

  assign o_rd_data = rd_data_q;
  assign o_flash_addr = addr_q;
  assign o_ce_n = ce_n_q;
  assign o_oe_n = oe_n_q;
  assign o_we_n = we_n_q;
  assign o_data = dout_q;
  assign o_data_oe = doe_q;

  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  double_read_a: assert property (
    (state_q == flash_status_pkg::ST_EVAL) && (op_q == flash_status_pkg::CMD_CHECK) &&
    (step_q == 2'h1) |-> (rd_cnt_q == 2'h2))
    else $error("toggle decided without two reads");

  done_no_toggle_a: assert property (
    (state_q == flash_status_pkg::ST_EVAL) && (op_q == flash_status_pkg::CMD_CHECK) &&
    (step_q == 2'h1) && !busy_tgl |=> flash_done_q && (state_q == flash_status_pkg::ST_IDLE))
    else $error("steady toggle not reported as done");

  fail_recheck_a: assert property (
    (state_q == flash_status_pkg::ST_EVAL) && (op_q == flash_status_pkg::CMD_CHECK) &&
    (step_q == 2'h1) && busy_tgl && last_q[flash_status_pkg::BIT_FAIL]
    |=> (state_q == flash_status_pkg::ST_ACT) && !is_wr_q && !failed_q)
    else $error("fail bit not rechecked");

  reset_after_fail_a: assert property (
    $rose(failed_q) |-> !we_n_q && doe_q && (dout_q == flash_status_pkg::FLASH_RESET_CMD))
    else $error("no reset command after failure");

  restart_check_a: assert property (
    (state_q == flash_status_pkg::ST_IDLE) && go && (cmd == flash_status_pkg::CMD_CHECK)
    |=> (step_q == 2'h0) && (rd_cnt_q == 2'h0) ##[1:20] (rd_cnt_q == 2'h1))
    else $error("check did not restart from first read");

  frame_hold_a: assert property (
    (state_q == flash_status_pkg::ST_ACT) && !is_wr_q && $past(state_q == flash_status_pkg::ST_ACT)
    |-> !ce_n_q && !oe_n_q && we_n_q)
    else $error("read strobes not held during access");

  window_before_a: assert property (
    $fell(we_n_q) && (dout_q == flash_status_pkg::FLASH_ERASE_CMD)
    |-> (rd_cnt_q == 2'h1) && !window_q ##1 !we_n_q [*4])
    else $error("sector added without window check");

  addr_stable_a: assert property (
    (state_q != flash_status_pkg::ST_IDLE) && $past(state_q != flash_status_pkg::ST_IDLE)
    |-> $stable(o_flash_addr))
    else $error("address moved during status operation");

  window_after_a: assert property (
    (state_q == flash_status_pkg::ST_EVAL) && (op_q == flash_status_pkg::CMD_ADD_ERASE) &&
    (step_q == 2'h2) |=> (not_acc_q == $past(last_q[flash_status_pkg::BIT_WINDOW])))
    else $error("window bit after add not reported");

endmodule : flash_status_host

// ==== verilog/flash_status_pkg.sv ====
// constants and types for the flash write-status host controller
// Behaviour
// - reads framed by output or chip enable
// - host combines sector and busy toggle bits
// - host reads full byte twice, compares toggle
// - unchanged toggle means operation finished
// - toggling with fail high: recheck, then reset
// - resumed check restarts from double read
// - host writes reset command after any failure
// - ignore window bit only under 50 us spacing; host has no spacing timer and checks the window bit on every add
// - host checks window before and after adding
// - host gives valid address for status reads
package flash_status_pkg;

  // timing
  localparam int CLK_MHZ = 100;
  localparam int T_ACC_NS = 100;
  localparam int T_REC_NS = 30;
  localparam int T_WP_NS = 50;
  localparam int SYNC_STAGES = 2;
  localparam logic [4:0] T_ACC_CYC = 5'((T_ACC_NS * CLK_MHZ + 999) / 1000);
  localparam logic [4:0] T_REC_CYC = 5'((T_REC_NS * CLK_MHZ + 999) / 1000);
  localparam logic [4:0] T_WP_CYC = 5'((T_WP_NS * CLK_MHZ + 999) / 1000);
  localparam logic [4:0] T_CAPTURE = 5'(T_ACC_CYC + 5'(SYNC_STAGES) - 5'h01);

  // register offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_DATA = 4'hc;

  // control fields
  localparam int CTRL_CMD_LSB = 0;
  localparam int CTRL_GO_BIT = 2;
  localparam int CTRL_CE_FRAME_BIT = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [19:0] ADDR_RESET = 20'h00000;

  // commands
  localparam logic [1:0] CMD_CHECK = 2'h0;
  localparam logic [1:0] CMD_STATUS = 2'h1;
  localparam logic [1:0] CMD_RESET = 2'h2;
  localparam logic [1:0] CMD_ADD_ERASE = 2'h3;

  // flash command bytes
  localparam logic [7:0] FLASH_RESET_CMD = 8'hf0;
  localparam logic [7:0] FLASH_ERASE_CMD = 8'h30;

  // status bit positions on the data byte lines
  localparam int BIT_DATA_POLL = 7;
  localparam int BIT_BUSY_TGL = 6;
  localparam int BIT_FAIL = 5;
  localparam int BIT_WINDOW = 3;
  localparam int BIT_SECT_TGL = 2;

  // status register fields
  localparam int ST_BUSY = 0;
  localparam int ST_FLASH_DONE = 1;
  localparam int ST_FAILED = 2;
  localparam int ST_TOGGLING = 3;
  localparam int ST_SECT_TGL = 4;
  localparam int ST_WINDOW = 5;
  localparam int ST_REFUSED = 6;
  localparam int ST_NOT_ACC = 7;
  localparam int ST_READY = 8;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_ACT = 4'h2,
    ST_REC = 4'h4,
    ST_EVAL = 4'h8
  } state_type;

endpackage : flash_status_pkg

// ==== verilog/sync2.sv ====
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module sync2 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // asynchronous input and synchronised output
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;

endmodule : sync2
